// ===== verilog/srx_pkg.sv
// Constants, field positions and types of the serial receive and
// interrupt control block.
// Assumes a single clock domain and one channel per instance.
package srx_pkg;
    // ---------------------------------------------------------------
    // Register pointer values.
    // ---------------------------------------------------------------
    localparam logic [2:0] REG_CMD = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_VEC = 3'h2;
    localparam logic [2:0] REG_RXP = 3'h3;
    localparam logic [2:0] RD_STAT = 3'h0;
    localparam logic [2:0] RD_SPEC = 3'h1;
    localparam logic [2:0] RD_VEC = 3'h2;
    localparam logic [7:0] REG_RST_VAL = 8'h00;
    // ---------------------------------------------------------------
    // Field positions.
    // ---------------------------------------------------------------
    localparam int MD_REQ_EN = 7;
    localparam int MD_REQ_FN = 6;
    localparam int MD_REQ_RX = 5;
    localparam int MD_RXI_LO = 3;
    localparam int MD_PAR_SP = 2;
    localparam int MD_TXI = 1;
    localparam int MD_EXT = 0;
    localparam int RP_LEN_LO = 6;
    localparam int RP_AUTO = 5;
    localparam int RP_HUNT = 4;
    localparam int RP_RXEN = 0;
    localparam int CMD_LO = 3;
    // ---------------------------------------------------------------
    // Commands, modes and vector status codes.
    // ---------------------------------------------------------------
    localparam logic [2:0] CMD_RST_EXT = 3'h2;
    localparam logic [2:0] CMD_NEXT_RX = 3'h4;
    localparam logic [2:0] CMD_RST_TX = 3'h5;
    localparam logic [2:0] CMD_ERR_RST = 3'h6;
    localparam logic [2:0] VS_TX = 3'h0;
    localparam logic [2:0] VS_EXT = 3'h1;
    localparam logic [2:0] VS_RX = 3'h2;
    localparam logic [2:0] VS_SPEC = 3'h3;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 11;
    typedef enum logic [1:0] {
        RXI_OFF = 2'h0, RXI_FIRST = 2'h1, RXI_ALL = 2'h2, RXI_SPEC = 2'h3
    } srx_rxi_type;
    typedef enum logic {WS_CMD = 1'b0, WS_REG = 1'b1} srx_wst_type;
    // Character length from the two length bits.
    function automatic logic [3:0] srx_char_len(input logic [1:0] code);
        case (code)
            2'h0: srx_char_len = 4'h5;
            2'h1: srx_char_len = 4'h7;
            2'h2: srx_char_len = 4'h6;
            default: srx_char_len = 4'h8;
        endcase
    endfunction : srx_char_len
endpackage : srx_pkg

// ===== verilog/srx_fifo.sv
// Receive character FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module srx_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rp_ff];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : srx_fifo

// ===== verilog/srx_ctrl.sv
// Per-channel receive, interrupt and wait/request control.
// Assumes CPU strobes, serial bit strobes and transmitter events are on
// the clock domain; modem pins are asynchronous and are synchronised.
// Overview of operation
// RL1: Request disabled holds pin inactive: high for request, floating for wait.
// RL2: Request function drives the pin low when ready to transfer a byte.
// RL3: Wait function pulls the pin low when CPU accesses data too early.
// RL4: Bit 5 selects receive buffer or transmit buffer as the tracked state.
// RL5: External request changes only while not selected; held during a cycle.
// RL6: Request-on-transmit in synchronous modes pulses low one clock at CRC end.
// RL7: Wait on receive for early reads, on transmit for writes when full.
// RL8: Mode 00 blocks receive interrupts; special status still shows in vector.
// RL9: Mode 01 interrupts on first character or special condition.
// RL10: Overrun, framing, end of frame, selected parity are special; held.
// RL11: Mode 01 special pending lasts until error reset, reset or mode 00.
// RL12: Mode 10 interrupts every character; overrun and parity latched.
// RL13: Mode 11 interrupts only on special characters, held until error reset.
// RL14: Bit 2 makes parity errors special, ignored when parity is off.
// RL15: Special status modifies the vector, driven out on interrupt acknowledge.
// RL16: Transmit interrupt enable requests an interrupt when buffer empties.
// RL17: Bit 0 gates all external/status interrupts; reset clears it.
// RL18: One vector register; status insertion by status and high/low bits.
// RL19: Length bits: 00 five, 01 seven, 10 six, 11 eight bits.
// RL20: Length change accepted mid-character; unused bits read one when framed.
// RL21: Auto enables let carrier gate receiver and clear-to-send transmitter.
// RL22: Enter hunt starts sync search; match clears hunt and interrupts.
// RL23: Error reset clears latched errors and releases the held character.
// RL24: Command 100 re-arms interrupt on the next received character.
module srx_ctrl (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chan_rst,
    input wire logic cpu_sel,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic cpu_data_sel,
    input wire logic [7:0] cpu_wdata,
    input wire logic int_ack,
    output logic [7:0] cpu_rdata,
    output logic cpu_rdata_oe,
    output logic wreq_out,
    output logic wreq_oe,
    output logic rx_irq,
    output logic tx_irq,
    output logic ext_irq,
    input wire logic carrier_detect_pin,
    input wire logic cts_pin,
    input wire logic sync_pin,
    input wire logic rx_bit_stb,
    input wire logic rx_bit,
    input wire logic rx_frame_err,
    input wire logic rx_end_frame,
    input wire logic rx_abort,
    input wire logic rx_break,
    input wire logic rx_sync_match,
    input wire logic tx_char_taken,
    input wire logic tx_crc_start,
    input wire logic tx_crc_done,
    input wire logic tx_underrun_latch,
    input wire logic baud_zero,
    input wire logic parity_en,
    input wire logic parity_even,
    input wire logic async_mode,
    input wire logic sdlc_mode,
    input wire logic local_loop,
    input wire logic auto_echo,
    input wire logic tx_en_bit,
    input wire logic vector_carries_status,
    input wire logic vec_status_high,
    output logic [7:0] tx_data,
    output logic tx_data_valid,
    output logic tx_enable,
    output logic rx_enable
);
    import srx_pkg::*;
    // ---------------------------------------------------------------
    // Register access and command decode.
    // ---------------------------------------------------------------
    logic rst;
    srx_wst_type wst_ff;
    logic [2:0] ptr_ff;
    logic [7:0] mode_ff;
    logic [7:0] vec_ff;
    logic [7:0] rxp_ff;
    logic ctl_wr;
    logic ctl_rd;
    logic reg_wr;
    logic [2:0] cmd;
    logic cmd_wr;
    srx_rxi_type rxi;
    logic rdy;
    logic dat_rd;
    logic dat_wr;

    assign rst = sys_rst | chan_rst;
    assign ctl_wr = cpu_sel & cpu_wr & ~cpu_data_sel;
    assign ctl_rd = cpu_sel & cpu_rd & ~cpu_data_sel;
    assign reg_wr = ctl_wr & (wst_ff == WS_REG);
    assign cmd_wr = ctl_wr & ((wst_ff == WS_CMD) | (ptr_ff == REG_CMD));
    assign cmd = cpu_wdata[CMD_LO+:3];
    assign rxi = srx_rxi_type'(mode_ff[MD_RXI_LO+:2]);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wst_ff <= WS_CMD;
            ptr_ff <= REG_CMD;
        end else if (ctl_wr | ctl_rd) begin
            wst_ff <= (ctl_wr & (wst_ff == WS_CMD) & (cpu_wdata[2:0] != REG_CMD)) ?
                WS_REG : WS_CMD;
            ptr_ff <= (ctl_wr & (wst_ff == WS_CMD)) ? cpu_wdata[2:0] : REG_CMD;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_ff <= REG_RST_VAL; // [RL17]
            rxp_ff <= REG_RST_VAL;
        end else if (reg_wr) begin
            if (ptr_ff == REG_MODE) begin
                mode_ff <= cpu_wdata;
            end
            if (ptr_ff == REG_RXP) begin
                rxp_ff <= cpu_wdata;
            end
        end
    end

    // Vector survives a channel reset, it is shared.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            vec_ff <= REG_RST_VAL;
        end else if (reg_wr & (ptr_ff == REG_VEC)) begin
            vec_ff <= cpu_wdata; // [RL18]
        end
    end

    // ---------------------------------------------------------------
    // Modem pin synchronisers and enables.
    // ---------------------------------------------------------------
    logic [1:0] dcd_sy_ff;
    logic [1:0] cts_sy_ff;
    logic [1:0] syn_sy_ff;
    logic [2:0] pin_old_ff;
    logic pin_chg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dcd_sy_ff <= 2'h0;
            cts_sy_ff <= 2'h0;
            syn_sy_ff <= 2'h0;
            pin_old_ff <= 3'h0;
        end else begin
            dcd_sy_ff <= {dcd_sy_ff[0], carrier_detect_pin};
            cts_sy_ff <= {cts_sy_ff[0], cts_pin};
            syn_sy_ff <= {syn_sy_ff[0], sync_pin};
            pin_old_ff <= {dcd_sy_ff[1], cts_sy_ff[1], syn_sy_ff[1]};
        end
    end
    assign pin_chg = pin_old_ff != {dcd_sy_ff[1], cts_sy_ff[1], syn_sy_ff[1]};

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
        end else begin
            tx_enable <= tx_en_bit & (~rxp_ff[RP_AUTO] | cts_sy_ff[1] | auto_echo |
                local_loop); // [RL21]
            rx_enable <= rxp_ff[RP_RXEN] & (~rxp_ff[RP_AUTO] | dcd_sy_ff[1] |
                local_loop); // [RL21]
        end
    end

    // ---------------------------------------------------------------
    // Hunt and character assembly.
    // ---------------------------------------------------------------
    logic hunt_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff;
    logic pbit_ff;
    logic [3:0] len;
    logic [3:0] tgt;
    logic [7:0] nsh;
    logic [7:0] mask;
    logic [7:0] alig;
    logic [7:0] chr;
    logic pb;
    logic par_err;
    logic asm_on;
    logic done;
    logic hunt_end;

    assign len = srx_char_len(rxp_ff[RP_LEN_LO+:2]); // [RL19]
    assign tgt = len + 4'(parity_en);
    assign asm_on = rx_enable & ~(hunt_ff & ~async_mode);
    assign nsh = (cnt_ff < len) ? {rx_bit, sh_ff[7:1]} : sh_ff;
    assign done = asm_on & rx_bit_stb & ((cnt_ff + 4'h1) >= tgt); // [RL20]
    assign mask = 8'hff << len;
    assign alig = nsh >> (4'h8 - len);
    assign chr = (async_mode | sdlc_mode) ? (alig | mask) : nsh; // [RL20]
    assign pb = (cnt_ff >= len) ? rx_bit : pbit_ff;
    assign par_err = parity_en & ((^alig) ^ pb ^ ~parity_even); // [RL14]
    assign hunt_end = hunt_ff & rx_sync_match;

    always_ff @(posedge clock) begin
        if (rst) begin
            hunt_ff <= 1'b1; // [RL22]
        end else if (rx_abort | ~rxp_ff[RP_RXEN] |
                (reg_wr & (ptr_ff == REG_RXP) & cpu_wdata[RP_HUNT])) begin
            hunt_ff <= 1'b1; // [RL22]
        end else if (rx_sync_match) begin
            hunt_ff <= 1'b0; // [RL22]
        end
    end

    always_ff @(posedge clock) begin
        if (rst | ~asm_on) begin
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            pbit_ff <= 1'b0;
        end else if (rx_bit_stb) begin
            cnt_ff <= done ? 4'h0 : cnt_ff + 4'h1;
            sh_ff <= done ? 8'h00 : nsh;
            pbit_ff <= pb;
        end
    end

    // ---------------------------------------------------------------
    // Receive FIFO and special conditions.
    // ---------------------------------------------------------------
    logic fin_ready;
    logic fout_valid;
    logic fout_ready;
    logic [10:0] fout_data;
    logic par_sp;
    logic head_spec;
    logic hold;
    logic err_rst;
    logic [3:0] spec_ff;
    logic spec_pend_ff;
    logic armed_ff;

    assign par_sp = par_err & mode_ff[MD_PAR_SP]; // [RL14]
    assign head_spec = fout_valid & (|fout_data[10:8]); // [RL10]
    assign hold = head_spec & ((rxi == RXI_FIRST) | (rxi == RXI_SPEC)); // [RL13]
    assign err_rst = cmd_wr & (cmd == CMD_ERR_RST);
    assign dat_rd = cpu_sel & cpu_rd & cpu_data_sel & fout_valid & ~hold; // [RL7]
    assign fout_ready = dat_rd | (err_rst & hold); // [RL23]

    srx_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(rst),
        .in_valid(done),
        .in_ready(fin_ready),
        .in_data({rx_end_frame, rx_frame_err, par_sp, chr}),
        .out_valid(fout_valid),
        .out_ready(fout_ready),
        .out_data(fout_data)
    );

    // Bits: 3 end of frame, 2 framing, 1 overrun, 0 parity.
    always_ff @(posedge clock) begin
        if (rst) begin
            spec_ff <= 4'h0;
        end else begin
            spec_ff <= (err_rst ? 4'h0 : spec_ff) | // [RL23]
                ({4{done}} & {rx_end_frame, rx_frame_err, ~fin_ready, par_sp}); // [RL12]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            spec_pend_ff <= 1'b0;
        end else if ((rxi != RXI_OFF) & ((head_spec & ~err_rst) | (done & ~fin_ready))) begin
            spec_pend_ff <= 1'b1; // [RL10]
        end else if (err_rst | (rxi == RXI_OFF)) begin
            spec_pend_ff <= 1'b0; // [RL11]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            armed_ff <= 1'b1;
        end else if (cmd_wr & (cmd == CMD_NEXT_RX)) begin
            armed_ff <= 1'b1; // [RL24]
        end else if (dat_rd & (rxi == RXI_FIRST)) begin
            armed_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Transmit buffer and interrupt sources.
    // ---------------------------------------------------------------
    logic tx_pend_ff;
    logic ext_pend_ff;
    logic rx_req;
    logic ext_evt;

    assign dat_wr = cpu_sel & cpu_wr & cpu_data_sel & ~tx_data_valid; // [RL7]
    assign ext_evt = pin_chg | rx_break | rx_abort | baud_zero | hunt_end |
        (tx_crc_start & tx_underrun_latch);

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_data_valid <= 1'b0;
            tx_data <= 8'h00;
        end else if (dat_wr) begin
            tx_data_valid <= 1'b1;
            tx_data <= cpu_wdata;
        end else if (tx_char_taken) begin
            tx_data_valid <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_pend_ff <= 1'b0;
        end else if (tx_char_taken & mode_ff[MD_TXI]) begin
            tx_pend_ff <= 1'b1; // [RL16]
        end else if (dat_wr | (cmd_wr & (cmd == CMD_RST_TX)) | ~mode_ff[MD_TXI]) begin
            tx_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ext_pend_ff <= 1'b0;
        end else if (ext_evt & mode_ff[MD_EXT]) begin
            ext_pend_ff <= 1'b1; // [RL17] [RL22]
        end else if ((cmd_wr & (cmd == CMD_RST_EXT)) | ~mode_ff[MD_EXT]) begin
            ext_pend_ff <= 1'b0; // [RL17]
        end
    end

    always_comb begin
        case (rxi)
            RXI_OFF: rx_req = 1'b0; // [RL8]
            RXI_FIRST: rx_req = (armed_ff & fout_valid) | spec_pend_ff; // [RL9]
            RXI_ALL: rx_req = fout_valid | spec_pend_ff; // [RL12]
            RXI_SPEC: rx_req = spec_pend_ff; // [RL13]
            default: rx_req = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
            ext_irq <= 1'b0;
        end else begin
            rx_irq <= rx_req;
            tx_irq <= tx_pend_ff;
            ext_irq <= ext_pend_ff;
        end
    end

    // ---------------------------------------------------------------
    // Vector, status read-back and data bus.
    // ---------------------------------------------------------------
    logic [2:0] vcode;
    logic [7:0] vmod;
    logic [7:0] stat;
    logic [7:0] rd_val;

    always_comb begin
        if (spec_pend_ff | (|spec_ff) | head_spec) begin
            vcode = VS_SPEC; // [RL8] [RL15]
        end else if (rx_req) begin
            vcode = VS_RX;
        end else if (tx_pend_ff) begin
            vcode = VS_TX;
        end else if (ext_pend_ff) begin
            vcode = VS_EXT;
        end else begin
            vcode = VS_TX;
        end
        if (~vector_carries_status) begin
            vmod = vec_ff; // [RL18]
        end else if (vec_status_high) begin
            vmod = {vec_ff[7], vcode[0], vcode[1], vcode[2], vec_ff[3:0]}; // [RL18]
        end else begin
            vmod = {vec_ff[7:4], vcode, vec_ff[0]}; // [RL18]
        end
    end

    assign stat = {rx_break, cts_sy_ff[1], hunt_ff, dcd_sy_ff[1], ~tx_data_valid,
        1'b0, 1'b0, fout_valid};
    always_comb begin
        case (ptr_ff)
            RD_STAT: rd_val = stat;
            RD_SPEC: rd_val = {spec_ff[3], spec_ff[2], spec_ff[1], spec_ff[0], 4'h0};
            RD_VEC: rd_val = vmod; // [RL8]
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
            cpu_rdata_oe <= 1'b0;
        end else begin
            cpu_rdata_oe <= int_ack | dat_rd | ctl_rd;
            if (int_ack) begin
                cpu_rdata <= vmod; // [RL15]
            end else if (dat_rd) begin
                cpu_rdata <= fout_data[7:0];
            end else if (ctl_rd) begin
                cpu_rdata <= rd_val;
            end
        end
    end

    // ---------------------------------------------------------------
    // Wait/request pin.
    // ---------------------------------------------------------------
    logic req_en;
    logic req_fn;
    logic req_rx;
    logic crc_pls;
    logic early;

    assign req_en = mode_ff[MD_REQ_EN];
    assign req_fn = mode_ff[MD_REQ_FN];
    assign req_rx = mode_ff[MD_REQ_RX];
    assign rdy = req_rx ? (fout_valid & ~hold) : ~tx_data_valid; // [RL4]
    assign crc_pls = req_en & req_fn & ~req_rx & ~async_mode & tx_crc_done; // [RL6]
    assign early = cpu_sel & cpu_data_sel & ((req_rx & cpu_rd & ~rdy) |
        (~req_rx & cpu_wr & ~rdy)); // [RL7]

    always_ff @(posedge clock) begin
        if (rst) begin
            wreq_out <= 1'b1;
            wreq_oe <= 1'b0;
        end else if (~req_en) begin
            wreq_out <= 1'b1; // [RL1]
            wreq_oe <= req_fn; // [RL1]
        end else if (req_fn) begin
            wreq_oe <= 1'b1;
            if (crc_pls) begin
                wreq_out <= 1'b0; // [RL6]
            end else if (~cpu_sel) begin
                wreq_out <= ~rdy; // [RL2] [RL5]
            end
        end else begin
            wreq_out <= 1'b0; // [RL3]
            wreq_oe <= early; // [RL3]
        end
    end

    // ---------------------------------------------------------------
    // Checks.
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_crc_end;
        tx_crc_done && req_en && req_fn && !req_rx && !async_mode;
    endsequence
    sequence s_low_once;
        !wreq_out && wreq_oe;
    endsequence

    a_req_disabled: assert property (!req_en && req_fn |=> wreq_out && wreq_oe) // [RL1]
        else $error("disabled request pin not high");
    a_wait_disabled: assert property (!req_en && !req_fn |=> !wreq_oe) // [RL1]
        else $error("disabled wait pin not floating");
    a_req_ready_low: assert property (req_en && req_fn && !cpu_sel && rdy && !crc_pls
        ##1 req_en && req_fn |-> !wreq_out) // [RL2]
        else $error("request not asserted when ready");
    a_req_held_sel: assert property (req_en && req_fn && cpu_sel && !crc_pls
        |=> $stable(wreq_out)) // [RL5]
        else $error("request changed during selected cycle");
    a_crc_pulse: assert property (s_crc_end |=> s_low_once) // [RL6]
        else $error("no request pulse at crc end");
    a_wait_early: assert property (req_en && !req_fn && early
        |=> wreq_oe && !wreq_out) // [RL3] [RL7]
        else $error("wait not driven on early access");
    a_rx_off_quiet: assert property (rxi == RXI_OFF ##1 rxi == RXI_OFF |-> !rx_irq) // [RL8]
        else $error("receive irq in disabled mode");
    a_err_rst_clear: assert property (err_rst && !done |=> spec_ff == 4'h0) // [RL23]
        else $error("error reset did not clear latches");
    a_hold_char: assert property (hold && !err_rst |=> fout_valid) // [RL13]
        else $error("held special character lost");
    a_tx_irq_set: assert property (tx_char_taken && mode_ff[MD_TXI]
        |=> tx_pend_ff ##1 tx_irq) // [RL16]
        else $error("tx empty did not raise irq");
endmodule : srx_ctrl

// ===== testbench/srx_host_model.sv
// Host CPU bus model that drives the controller's access strobes.
// Assumes inputs change at the falling edge and reads answer within three cycles.
module srx_host_model (
    input wire logic clock,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rdata_oe,
    input wire logic wreq_out,
    input wire logic wreq_oe,
    output logic cpu_sel,
    output logic cpu_rd,
    output logic cpu_wr,
    output logic cpu_data_sel,
    output logic [7:0] cpu_wdata,
    output logic int_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_low = 1'b0;
    initial begin
        {cpu_sel, cpu_rd, cpu_wr, cpu_data_sel, int_ack} = 5'h00;
        cpu_wdata = 8'h00;
    end
    // Kind 0 writes, 1 reads, 2 acknowledges; pin_low notes a driven low wait pin.
    task automatic acc(input logic [1:0] k, input logic ds, input logic [7:0] d,
            output logic [7:0] q);
        @(negedge clock);
        {cpu_sel, cpu_wr, cpu_rd, int_ack} = {k != 2'h2, k == 2'h0, k == 2'h1, k == 2'h2};
        cpu_data_sel = ds;
        cpu_wdata = d;
        pin_low = 1'b0;
        q = 8'h00;
        @(negedge clock);
        {cpu_sel, cpu_rd, cpu_wr, int_ack} = 4'h0;
        cpu_wdata = ~d;
        for (int i = 0; i < 3; i++) begin
            pin_low |= wreq_oe & ~wreq_out;
            if (cpu_rdata_oe) q = cpu_rdata;
            @(negedge clock);
        end
    endtask : acc
endmodule : srx_host_model

// ===== testbench/testbench.sv
// Self-checking bench of the receive, interrupt and wait/request control.
// Assumes the host model drives the CPU bus of the controller.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import srx_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, chan_rst = 1'b0, rx_bit_stb = 1'b0, rx_bit = 1'b0;
    logic rx_frame_err = 1'b0, cpu_sel, cpu_rd, cpu_wr, cpu_data_sel, int_ack;
    logic cpu_rdata_oe, wreq_out, wreq_oe, rx_irq, tx_irq, ext_irq, tx_data_valid;
    logic [7:0] cpu_wdata, cpu_rdata, tx_data, q;
    logic [3:0] ev = 4'h0;
    logic [11:0] lv = 12'h000;
    int fail_count = 0, check_count = 0;
    int len[4] = '{5, 7, 6, 8};
    srx_host_model i_host (.clock, .cpu_rdata, .cpu_rdata_oe, .wreq_out, .wreq_oe,
        .cpu_sel, .cpu_rd, .cpu_wr, .cpu_data_sel, .cpu_wdata, .int_ack);
    srx_ctrl i_dut (.clock, .sys_rst, .chan_rst, .cpu_sel, .cpu_rd, .cpu_wr, .cpu_data_sel,
        .cpu_wdata, .int_ack, .cpu_rdata, .cpu_rdata_oe, .wreq_out, .wreq_oe, .rx_irq,
        .tx_irq, .ext_irq, .carrier_detect_pin(lv[0]), .cts_pin(lv[1]), .sync_pin(lv[2]),
        .rx_bit_stb, .rx_bit, .rx_frame_err, .rx_end_frame(lv[3]), .rx_abort(lv[4]),
        .rx_break(ev[0]), .rx_sync_match(lv[5]), .tx_char_taken(ev[3]),
        .tx_crc_start(ev[2]), .tx_crc_done(lv[6]), .tx_underrun_latch(1'b1),
        .baud_zero(ev[1]), .parity_en(lv[7]), .parity_even(lv[8]), .async_mode(1'b1),
        .sdlc_mode(lv[9]), .local_loop(lv[10]), .auto_echo(1'b0), .tx_en_bit(1'b0),
        .vector_carries_status(1'b1), .vec_status_high(lv[11]), .tx_data, .tx_data_valid,
        .tx_enable(), .rx_enable());
    initial forever #4 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic wreg(input logic [2:0] p, input logic [7:0] v);
        i_host.acc(2'h0, 1'b0, {5'h00, p}, q);
        i_host.acc(2'h0, 1'b0, v, q);
    endtask : wreg
    task automatic rreg(input logic [2:0] p);
        i_host.acc(2'h0, 1'b0, {5'h00, p}, q);
        i_host.acc(2'h1, 1'b0, 8'h00, q);
    endtask : rreg
    task automatic rxc(input logic [7:0] c, input int n, input logic fe);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            {rx_bit_stb, rx_bit, rx_frame_err} = {1'b1, c[i], fe && i == n - 1};
            @(negedge clock);
            {rx_bit_stb, rx_bit, rx_frame_err} = {1'b0, ~rx_bit, 1'b0};
        end
        repeat (3) @(negedge clock);
    endtask : rxc
    task automatic pulse(input logic [3:0] e);
        ev = e;
        @(negedge clock);
        ev = 4'h0;
        repeat (3) @(negedge clock);
    endtask : pulse
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        chk({wreq_out, wreq_oe, rx_irq, tx_irq, ext_irq, 3'h0}, 8'h80);
        wreg(REG_VEC, 8'hf1);
        wreg(REG_MODE, 8'he0);
        chk({7'h00, wreq_out}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wreg(REG_RXP, {k[1:0], 6'h01});
            rxc(8'h00, len[k], 1'b0);
            chk({7'h00, wreq_out}, 8'h00);
            i_host.acc(2'h1, 1'b1, 8'h00, q);
            chk(q, 8'hff << len[k]);
        end
        rxc(8'h3c, 8, 1'b1);
        chk({7'h00, rx_irq}, 8'h00);
        rreg(RD_VEC);
        chk(q, 8'hf7);
        i_host.acc(2'h1, 1'b1, 8'h00, q);
        i_host.acc(2'h0, 1'b0, {2'h0, CMD_ERR_RST, 3'h0}, q);
        wreg(REG_MODE, 8'h18);
        rxc(8'h3c, 8, 1'b1);
        chk({7'h00, rx_irq}, 8'h01);
        rreg(RD_SPEC);
        chk(q, 8'h40);
        lv[11] = 1'b1;
        i_host.acc(2'h2, 1'b0, 8'h00, q);
        chk(q, 8'he1);
        i_host.acc(2'h0, 1'b0, {2'h0, CMD_ERR_RST, 3'h0}, q);
        rreg(RD_SPEC);
        chk({q[6:0], rx_irq}, 8'h00);
        for (int k = 1; k < 3; k++) begin
            wreg(REG_MODE, {3'h0, k[1:0], 3'h0});
            i_host.acc(2'h0, 1'b0, {2'h0, CMD_NEXT_RX, 3'h0}, q);
            rxc(8'h55, 8, 1'b0);
            chk({7'h00, rx_irq}, 8'h01);
            i_host.acc(2'h1, 1'b1, 8'h00, q);
            chk(q, 8'h55);
        end
        wreg(REG_MODE, 8'h82);
        i_host.acc(2'h0, 1'b1, 8'h5a, q);
        chk({7'h00, i_host.pin_low}, 8'h00);
        i_host.acc(2'h0, 1'b1, 8'ha5, q);
        chk({7'h00, i_host.pin_low}, 8'h01);
        chk(tx_data, 8'h5a);
        pulse(4'h8);
        chk({7'h00, tx_irq}, 8'h01);
        wreg(REG_MODE, 8'h01);
        for (int k = 0; k < 3; k++) begin
            pulse(4'h1 << k);
            chk({7'h00, ext_irq}, 8'h01);
            i_host.acc(2'h0, 1'b0, {2'h0, CMD_RST_EXT, 3'h0}, q);
            chk({7'h00, ext_irq}, 8'h00);
        end
        chan_rst = 1'b1;
        repeat (2) @(negedge clock);
        chan_rst = 1'b0;
        pulse(4'h2);
        chk({7'h00, ext_irq}, 8'h00);
        test_done();
    end
endmodule : testbench
